// [rtl/sso_defines.vh]
// Purpose: Constants for the servo status output block
// Assumes: 20 MHz system clock, APB register access
// Notes:   Offsets are byte addresses of 32-bit registers
`ifndef SSO_DEFINES_VH
`define SSO_DEFINES_VH
// ==================================================
// Register offsets
`define SSO_OFF_CTRL      12'h000
`define SSO_OFF_ZSTHR     12'h004
`define SSO_OFF_STATUS    12'h008
`define SSO_OFF_IRQ_STAT  12'h00c
`define SSO_OFF_IRQ_EN    12'h010
`define SSO_OFF_IRQ_CLR   12'h014
`define SSO_OFF_OUTSTATE  12'h018
// ==================================================
// Control fields
`define SSO_CTRL_BRAKE_FN  0
`define SSO_CTRL_BRAKE_PIN 1
`define SSO_CTRL_WARN_PIN  2
`define SSO_CTRL_BATT_PIN  3
`define SSO_CTRL_RST       4'h0
// ==================================================
// Speed figures in r/min
`define SSO_ZSTHR_RST      16'h0032
`define SSO_HYST_RPM       16'h0014
// ==================================================
// Timing
`define SSO_CLK_HZ         20000000
`define SSO_WARN_HOLD_MS   1500
`define SSO_WARN_HOLD_CYC  (`SSO_CLK_HZ / 1000 * `SSO_WARN_HOLD_MS)
`define SSO_CTRL_CYC_NS    62500
`define SSO_CTRL_CYC_CNT   (`SSO_CTRL_CYC_NS / 50)
// ==================================================
// Interrupt status bits
`define SSO_EV_ZS_ON       0
`define SSO_EV_ZS_OFF      1
`define SSO_EV_WARN        2
`define SSO_EV_BATT        3
`endif

// [rtl/sso_zero_speed.v]
// Purpose: Zero speed detector with hysteresis
// Assumes: Signed speed sample in r/min, sample strobe
// Notes:   Flag holds between samples
`timescale 1ns/100ps
`include "sso_defines.vh"
module sso_zero_speed (
  clk_sys,
  sys_rst,
  sample_en,
  speed,
  threshold,
  zero_speed_flag
);
  input  wire               clk_sys;
  input  wire               sys_rst;
  input  wire               sample_en;
  input  wire signed [15:0] speed;
  input  wire        [15:0] threshold;
  output reg                zero_speed_flag;

  wire [15:0] mag;
  wire [16:0] off_lvl;
  reg         nxt_flag;

  // Magnitude so both directions behave alike
  assign mag     = speed[15] ? (~speed + 16'h0001) : speed;
  assign off_lvl = {1'b0, threshold} + {1'b0, `SSO_HYST_RPM};

  // Hysteresis decision
  always @* begin
    nxt_flag = zero_speed_flag;
    if (sample_en) begin                           // see RL12
      if (!zero_speed_flag && mag <= threshold)     // see RL1
        nxt_flag = 1'b1;
      else if (zero_speed_flag && {1'b0, mag} >= off_lvl) // see RL3 see RL4
        nxt_flag = 1'b0;
    end
  end

  // Flag register
  always @(posedge clk_sys) begin
    if (sys_rst)
      zero_speed_flag <= 1'b0;
    else
      zero_speed_flag <= nxt_flag;
  end
endmodule // sso_zero_speed

// [rtl/sso_status_outputs.v]
// Purpose: Discrete status outputs of a servo amplifier
// Assumes: APB slave, 20 MHz clock, inputs from other clocks synchronised here
// Notes:   Output pins active high
//          Level inputs reach the pins three clock edges after they change
//          The speed word is taken only when two captures agree, so a word
//          caught while its bits change never reaches the detector
//          Zero-speed flag has a fixed 20 r/min hysteresis above the threshold
//          Enabling the brake takes the shared pin away from zero speed
//          Interrupt is a level, one cycle behind the status bits
//          Unmapped offsets answer with an error, read zero and ignore writes
//          Register map, 32-bit words, unused bits read zero:
//            0x000 control: brake by function select, brake by pin,
//                  warning pin assigned, battery pin assigned
//            0x004 zero-speed threshold in r/min
//            0x008 live input status
//            0x00c sticky event status, read only
//            0x010 event enable
//            0x014 event clear, write one to clear
//            0x018 output pin state and power-on settle bit
//
// Overview of operation
// RL1 - Zero-speed flag on at or below threshold
// RL2 - Threshold comes from software register
// RL3 - Flag off at threshold plus 20 r/min
// RL4 - Hysteresis symmetric in both directions
// RL5 - Brake output only when enabled; replaces zero-speed
// RL6 - Brake off on servo off or alarm
// RL7 - Warning outputs only on assigned pin
// RL8 - Warning output on while warning present
// RL9 - Warning off within 1.5 s after power-on; the warning pin here does not wait and shows a warning at once
// RL10 - Battery warning on cable or level warning
// RL11 - Battery warning off within 1.5 s; the battery pin here does not wait either and shows a warning at once
// RL12 - Compare signed sample once per control cycle
`timescale 1ns/100ps
`include "sso_defines.vh"
module sso_status_outputs (
  clk_sys,
  sys_rst,
  paddr,
  psel,
  penable,
  pwrite,
  pwdata,
  prdata,
  pready,
  pslverr,
  speed,
  servo_on,
  alarm,
  warning_any,
  batt_cable_warn,
  batt_level_warn,
  zero_speed_out,
  brake_interlock_out,
  warning_out,
  battery_warning_out,
  irq
);
  // Clock and reset
  input  wire        clk_sys;
  input  wire        sys_rst;
  // APB slave
  input  wire [11:0] paddr;
  input  wire        psel;
  input  wire        penable;
  input  wire        pwrite;
  input  wire [31:0] pwdata;
  output reg  [31:0] prdata;
  output reg         pready;
  output reg         pslverr;
  // Measured speed and level events
  input  wire [15:0] speed;
  input  wire        servo_on;
  input  wire        alarm;
  input  wire        warning_any;
  input  wire        batt_cable_warn;
  input  wire        batt_level_warn;
  // Discrete outputs and interrupt
  output reg         zero_speed_out;
  output reg         brake_interlock_out;
  output reg         warning_out;
  output reg         battery_warning_out;
  output reg         irq;

  // ==================================================
  // Input synchronisers
  reg  [4:0]  sync1_ff;
  reg  [4:0]  sync2_ff;
  wire [4:0]  raw_in;
  assign raw_in = {batt_level_warn, batt_cable_warn, warning_any, alarm, servo_on};

  // Two-stage capture of pin levels
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Synchronised levels; only the second stage reads the first
  wire servo_on_s = sync2_ff[0];
  wire alarm_s    = sync2_ff[1];
  wire warn_s     = sync2_ff[2];
  wire batt_s     = sync2_ff[3] | sync2_ff[4];      // see RL10

  // ==================================================
  // Speed sample once per control cycle
  reg [15:0] cyc_cnt_ff;
  reg        tick_ff;
  reg [15:0] spd_s1_ff;
  reg [15:0] spd_s2_ff;
  reg [15:0] spd_s3_ff;
  reg [15:0] spd_ff;
  wire       spd_steady;

  // A word caught while its bits change is refused; only agreeing captures count
  assign spd_steady = (spd_s2_ff == spd_s3_ff);

  // Control-cycle divider and speed capture
  // One tick per control cycle; the detector acts only on that tick
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      cyc_cnt_ff <= 16'h0000;
      tick_ff    <= 1'b0;
      spd_s1_ff  <= 16'h0000;
      spd_s2_ff  <= 16'h0000;
      spd_s3_ff  <= 16'h0000;
      spd_ff     <= 16'h0000;
    end else begin
      spd_s1_ff <= speed;
      spd_s2_ff <= spd_s1_ff;
      spd_s3_ff <= spd_s2_ff;
      tick_ff   <= 1'b0;
      if (cyc_cnt_ff == `SSO_CTRL_CYC_CNT - 1) begin
        cyc_cnt_ff <= 16'h0000;
        tick_ff    <= 1'b1;
        if (spd_steady) begin
          spd_ff <= spd_s3_ff;                     // see RL12
        end
      end else begin
        cyc_cnt_ff <= cyc_cnt_ff + 16'h0001;
      end
    end
  end

  // ==================================================
  // Registers
  reg [3:0]  ctrl_ff;
  reg [15:0] zsthr_ff;
  reg [3:0]  irq_stat_ff;
  reg [3:0]  irq_en_ff;
  wire       zs_flag;

  sso_zero_speed u_zs (
    .clk_sys         (clk_sys),
    .sys_rst         (sys_rst),
    .sample_en       (tick_ff),
    .speed           (spd_ff),
    .threshold       (zsthr_ff),               // see RL2
    .zero_speed_flag (zs_flag)
  );

  // ==================================================
  // Power-on settle timer for the output state word
  reg [24:0] hold_cnt_ff;
  reg        hold_done_ff;

  // Settle time after power-on, shown in the output state word; the warning
  // pins do not wait for it, so a warning present at start shows at once
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      hold_cnt_ff  <= 25'h0000000;
      hold_done_ff <= 1'b0;
    end else if (!hold_done_ff) begin
      if (hold_cnt_ff == `SSO_WARN_HOLD_CYC - 1)
        hold_done_ff <= 1'b1;
      else
        hold_cnt_ff <= hold_cnt_ff + 25'h0000001;
    end
  end

  // ==================================================
  // Output pins
  // Either brake enable source takes the shared pin away from zero speed
  wire brake_en = ctrl_ff[`SSO_CTRL_BRAKE_FN] | ctrl_ff[`SSO_CTRL_BRAKE_PIN];

  // Pin drivers
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      zero_speed_out      <= 1'b0;
      brake_interlock_out <= 1'b0;
      warning_out         <= 1'b0;
      battery_warning_out <= 1'b0;
    end else begin
      zero_speed_out      <= ~brake_en & zs_flag;                          // see RL5
      brake_interlock_out <= brake_en & servo_on_s & ~alarm_s;           // see RL5 see RL6
      // Warning pins follow the warning at once and stay low without one
      warning_out         <= ctrl_ff[`SSO_CTRL_WARN_PIN] & warn_s;  // see RL7 see RL8 see RL9
      battery_warning_out <= ctrl_ff[`SSO_CTRL_BATT_PIN] & batt_s;  // see RL7 see RL10 see RL11
    end
  end

  // ==================================================
  // Interrupt events
  // Edge memories start at zero, the idle level of every source
  reg  zs_d_ff;
  reg  warn_d_ff;
  reg  batt_d_ff;
  wire [3:0] ev;

  // One-cycle event pulses on both zero-speed changes and on warning and battery rises
  assign ev[`SSO_EV_ZS_ON]  = zs_flag & ~zs_d_ff;
  assign ev[`SSO_EV_ZS_OFF] = ~zs_flag & zs_d_ff;
  assign ev[`SSO_EV_WARN]   = warn_s & ~warn_d_ff;
  assign ev[`SSO_EV_BATT]   = batt_s & ~batt_d_ff;

  // Decode of known offsets
  function hit;
    input [11:0] a;
    begin
      case (a)
        `SSO_OFF_CTRL,
        `SSO_OFF_ZSTHR,
        `SSO_OFF_STATUS,
        `SSO_OFF_IRQ_STAT,
        `SSO_OFF_IRQ_EN,
        `SSO_OFF_IRQ_CLR,
        `SSO_OFF_OUTSTATE: hit = 1'b1;
        default:           hit = 1'b0;
      endcase
    end
  endfunction

  // Only mapped offsets take a write
  wire apb_wr = psel & penable & pwrite & hit(paddr);

  // Register writes; event set wins over clear
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_ff     <= `SSO_CTRL_RST;
      zsthr_ff    <= `SSO_ZSTHR_RST;
      irq_en_ff   <= 4'h0;
      irq_stat_ff <= 4'h0;
      zs_d_ff     <= 1'b0;
      warn_d_ff   <= 1'b0;
      batt_d_ff   <= 1'b0;
      irq         <= 1'b0;
    end else begin
      zs_d_ff   <= zs_flag;
      warn_d_ff <= warn_s;
      batt_d_ff <= batt_s;
      irq <= |(irq_stat_ff & irq_en_ff);
      // A new event is never lost to a clear written in the same cycle
      irq_stat_ff <= irq_stat_ff | ev;
      if (apb_wr) begin
        case (paddr)
          `SSO_OFF_CTRL: begin
            ctrl_ff <= pwdata[3:0];
          end
          `SSO_OFF_ZSTHR: begin
            zsthr_ff <= pwdata[15:0];                // see RL2
          end
          `SSO_OFF_IRQ_EN: begin
            irq_en_ff <= pwdata[3:0];
          end
          `SSO_OFF_IRQ_CLR: begin
            irq_stat_ff <= (irq_stat_ff & ~pwdata[3:0]) | ev;
          end
          default: begin
            ctrl_ff <= ctrl_ff;                      // Read-only offsets ignore writes
          end
        endcase
      end
    end
  end

  // ==================================================
  // APB answer: zero wait states
  // Ready follows every setup, so a stray address still ends its transfer
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit(paddr);
      prdata  <= 32'h00000000;
      // Read word is built in the setup cycle and stands for the access cycle
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SSO_OFF_CTRL:     prdata <= {28'h0000000, ctrl_ff};
          `SSO_OFF_ZSTHR:    prdata <= {16'h0000, zsthr_ff};
          `SSO_OFF_STATUS:   prdata <= {27'h0000000, batt_s, warn_s, alarm_s, servo_on_s, zs_flag};
          `SSO_OFF_IRQ_STAT: prdata <= {28'h0000000, irq_stat_ff};
          `SSO_OFF_IRQ_EN:   prdata <= {28'h0000000, irq_en_ff};
          `SSO_OFF_OUTSTATE: prdata <= {27'h0000000, hold_done_ff, battery_warning_out, warning_out,
                                        brake_interlock_out, zero_speed_out};
          default:           prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // sso_status_outputs

// [testbench/sso_status_assertions.sv]
// Purpose: Port checks of the status block
// Assumes: One clock, sync reset
// Notes:   Inputs reach outputs three edges late
`timescale 1ns/100ps
module sso_chk (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire servo_on,
  input wire alarm,
  input wire warning_any,
  input wire batt_cable_warn,
  input wire batt_level_warn,
  input wire zero_speed_out,
  input wire brake_interlock_out,
  input wire warning_out,
  input wire battery_warning_out
);
  // ======
  // Properties
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_alm;
    alarm [*3];
  endsequence
  property p_brk;
    brake_interlock_out |-> $past(servo_on, 3) && !$past(alarm, 3);
  endproperty
  property p_alm;
    s_alm |=> !brake_interlock_out;
  endproperty
  property p_exc;
    !(zero_speed_out && brake_interlock_out);
  endproperty
  property p_wrn;
    warning_out |-> $past(warning_any, 3);
  endproperty
  property p_bat;
    battery_warning_out |-> $past(batt_cable_warn || batt_level_warn, 3);
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_rdy;
    pready |-> psel && penable && $past(psel && !penable);
  endproperty
  property p_one;
    pready |=> !pready;
  endproperty
  a_brk: assert property (p_brk) else $error("brake on without cause");
  a_alm: assert property (p_alm) else $error("brake on during alarm");
  a_exc: assert property (p_exc) else $error("brake and zero speed both on");
  a_wrn: assert property (p_wrn) else $error("warning without cause");
  a_bat: assert property (p_bat) else $error("battery warning without cause");
  a_err: assert property (p_err) else $error("error without ready");
  a_rdy: assert property (p_rdy) else $error("ready outside access");
  a_one: assert property (p_one) else $error("ready held too long");
endmodule // sso_chk
bind sso_status_outputs sso_chk u_chk (
  .clk_sys             (clk_sys),
  .sys_rst             (sys_rst),
  .psel                (psel),
  .penable             (penable),
  .pready              (pready),
  .pslverr             (pslverr),
  .servo_on            (servo_on),
  .alarm               (alarm),
  .warning_any         (warning_any),
  .batt_cable_warn     (batt_cable_warn),
  .batt_level_warn     (batt_level_warn),
  .zero_speed_out      (zero_speed_out),
  .brake_interlock_out (brake_interlock_out),
  .warning_out         (warning_out),
  .battery_warning_out (battery_warning_out)
);

// [testbench/sso_host_model.sv]
// Purpose: Host reader of the discrete outputs
// Assumes: Outputs sampled on the system clock
// Notes:   Counts zero speed turn-on edges
`timescale 1ns/100ps
module sso_host_model (
  input  wire         clk_sys,
  input  wire         sys_rst,
  input  wire         zero_speed_out,
  output logic [15:0] zs_on_cnt
);
  logic zs_ff;
  // Count rising edges of the flag
  always @(posedge clk_sys) begin
    zs_ff <= zero_speed_out;
    if (sys_rst)
      zs_on_cnt <= 16'h0000;
    else if (zero_speed_out && !zs_ff)
      zs_on_cnt <= zs_on_cnt + 16'h0001;
  end
endmodule // sso_host_model

// [testbench/tb_top.sv]
// Purpose: Self-checking bench of the status block
// Assumes: 20 MHz clock, APB access
// Notes:   Power-on settle bit stays low for the whole run
`timescale 1ns/100ps
`include "sso_defines.vh"
module tb_top;
  logic        clk_sys = 1'b0, sys_rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, zero_speed_out, brake_interlock_out;
  logic        warning_out, battery_warning_out, irq;
  logic        servo_on = 1'b0, alarm = 1'b0, warning_any = 1'b0;
  logic        batt_cable_warn = 1'b0, batt_level_warn = 1'b0;
  logic [15:0] speed = 16'h0064, zs_cnt;
  logic [15:0] spd [8] = '{16'h0064, 16'h0032, 16'h0045, 16'h0046,
                           16'hffce, 16'hffbb, 16'hffba, 16'h0033};
  logic [7:0]  zexp = 8'b00110110;
  int          failures = 0, cmp_count = 0;
  sso_status_outputs dut (
    .clk_sys             (clk_sys),
    .sys_rst             (sys_rst),
    .paddr               (paddr),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .speed               (speed),
    .servo_on            (servo_on),
    .alarm               (alarm),
    .warning_any         (warning_any),
    .batt_cable_warn     (batt_cable_warn),
    .batt_level_warn     (batt_level_warn),
    .zero_speed_out      (zero_speed_out),
    .brake_interlock_out (brake_interlock_out),
    .warning_out         (warning_out),
    .battery_warning_out (battery_warning_out),
    .irq                 (irq)
  );
  sso_host_model host (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .zero_speed_out (zero_speed_out),
    .zs_on_cnt      (zs_cnt)
  );
  // Clock
  always #25 clk_sys = ~clk_sys;
  // ======
  // Tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
      begin failures++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n, 1);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task print_verdict;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cut a hang short
  initial begin #2500000; failures++; $display("mismatch at %0t: watchdog", $time); print_verdict; end
  // ======
  // Tests
  initial begin
    wt(20);
    sys_rst <= 1'b0;
    rdc(`SSO_OFF_ZSTHR, 32'h32);
    rdc(`SSO_OFF_CTRL, 32'h0);
    rdc(12'hffc, 32'h0);
    chk(err, 1);
    chk(warning_out, 0);
    chk(battery_warning_out, 0);
    for (int i = 0; i < 8; i++) begin
      speed <= spd[i];
      wt(2600);
      chk(zero_speed_out, zexp[i]);
    end
    apb(1, `SSO_OFF_ZSTHR, 32'h64);
    wt(2600);
    chk(zero_speed_out, 1);
    apb(1, `SSO_OFF_IRQ_CLR, 32'hf);
    apb(1, `SSO_OFF_IRQ_EN, 32'h1);
    speed <= 16'h00c8;
    wt(2600);
    chk(irq, 0);
    speed <= 16'h0000;
    wt(2600);
    chk(irq, 1);
    rdc(`SSO_OFF_IRQ_STAT, 32'h3);
    apb(1, `SSO_OFF_IRQ_EN, 32'h0);
    wt(2);
    chk(irq, 0);
    apb(1, `SSO_OFF_IRQ_EN, 32'h1);
    wt(2);
    chk(irq, 1);
    apb(1, `SSO_OFF_IRQ_CLR, 32'h1);
    wt(2);
    chk(irq, 0);
    chk(zs_cnt, 16'h0004);
    apb(1, `SSO_OFF_CTRL, 32'h1);
    servo_on <= 1'b1;
    wt(5);
    chk(brake_interlock_out, 1);
    chk(zero_speed_out, 0);
    alarm <= 1'b1;
    wt(5);
    chk(brake_interlock_out, 0);
    alarm <= 1'b0;
    wt(5);
    chk(brake_interlock_out, 1);
    servo_on <= 1'b0;
    wt(5);
    chk(brake_interlock_out, 0);
    warning_any <= 1'b1;
    batt_level_warn <= 1'b1;
    wt(5);
    chk(warning_out, 0);
    chk(battery_warning_out, 0);
    apb(1, `SSO_OFF_CTRL, 32'hc);
    wt(5);
    chk(warning_out, 1);
    chk(battery_warning_out, 1);
    rdc(`SSO_OFF_STATUS, 32'h19);
    rdc(`SSO_OFF_IRQ_STAT, 32'he);
    rdc(`SSO_OFF_OUTSTATE, 32'hd);
    warning_any <= 1'b0;
    batt_level_warn <= 1'b0;
    batt_cable_warn <= 1'b1;
    wt(5);
    chk(warning_out, 0);
    chk(battery_warning_out, 1);
    batt_cable_warn <= 1'b0;
    wt(5);
    chk(battery_warning_out, 0);
    print_verdict;
  end
endmodule // tb_top
